// File: core/cam_port_pkg.sv
// Shared constants, types and helpers for the camera sensor input port.
// Assumes a 25 MHz system clock and an APB master with 32-bit data.
package cam_port_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 20;
  localparam int unsigned COMP_W = 10;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned CNT_W = 16;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 12'h004;
  localparam logic [ADDR_W-1:0] FRAME_CNT_OFFS = 12'h008;
  localparam logic [ADDR_W-1:0] LINE_LEN_OFFS = 12'h00C;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_FS_FALL_BIT = 3;
  localparam int unsigned CTRL_LS_LOW_BIT = 4;
  localparam int unsigned CTRL_PCLK_FALL_BIT = 5;
  localparam int unsigned CTRL_FMT_LSB = 6;

  // ----------------------------------------------------------------
  // Timing code layout on a 10-bit component lane
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_PREAMBLE = 8'hFF;
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam int unsigned CODE_ONE_BIT = 9;
  localparam int unsigned CODE_F_BIT = 8;
  localparam int unsigned CODE_V_BIT = 7;
  localparam int unsigned CODE_H_BIT = 6;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_EMBEDDED = 2'b00,
    MODE_GATED = 2'b01,
    MODE_NONGATED = 2'b10
  } mode_e;

  typedef enum logic [1:0] {
    FMT_YCC8 = 2'b00,
    FMT_YCC20 = 2'b01,
    FMT_GENERIC16 = 2'b10,
    FMT_RGB565 = 2'b11
  } fmt_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ONE = 2'b01,
    SEQ_TWO = 2'b10,
    SEQ_THREE = 2'b11
  } seq_e;

  typedef enum logic [1:0] {
    TRK_WAIT = 2'b00,
    TRK_FRAME = 2'b01,
    TRK_LINE = 2'b10
  } trk_e;

  // ----------------------------------------------------------------
  // Colour extension helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] ext8to10(input logic [7:0] c);
    return {c, c[7:6]};
  endfunction

  function automatic logic [5:0] ext5to6(input logic [4:0] c);
    return {c, c[4]};
  endfunction

endpackage

// File: core/code_if.sv
// Carrier between the port and its timing code decoder.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface code_if;
  logic sample_valid;
  logic [9:0] lane;
  logic strip;
  logic code_hit;
  logic code_f;
  logic code_v;
  logic code_h;

  modport dec (
    input sample_valid, lane,
    output strip, code_hit, code_f, code_v, code_h
  );
  modport host (
    output sample_valid, lane,
    input strip, code_hit, code_f, code_v, code_h
  );
endinterface

// File: core/timing_code_decoder.sv
// Finds the four-word timing codes in the embedded-sync component stream.
// Assumes one lane sample per valid pixel clock, already left-justified.
`timescale 1ns/100ps
module timing_code_decoder
  import cam_port_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clear,
  code_if.dec cif
);

  seq_e seq_q;
  seq_e seq_d;
  logic pre;
  logic zero;

  // Only the top eight bits are compared so 8-bit and 10-bit lanes share it
  assign pre = cif.lane[9:2] == CODE_PREAMBLE;
  assign zero = cif.lane[9:2] == CODE_ZERO;
  assign cif.code_f = cif.lane[CODE_F_BIT];
  assign cif.code_v = cif.lane[CODE_V_BIT];
  assign cif.code_h = cif.lane[CODE_H_BIT];

  // Code sequence walk; every word that belongs to a code is marked for removal
  always_comb begin
    seq_d = seq_q;
    cif.strip = 1'b0;
    cif.code_hit = 1'b0;
    if (cif.sample_valid) begin
      case (seq_q)
        SEQ_IDLE: begin
          if (pre) begin
            cif.strip = 1'b1;
            seq_d = SEQ_ONE;
          end
        end
        SEQ_ONE: begin
          cif.strip = pre | zero;
          seq_d = zero ? SEQ_TWO : (pre ? SEQ_ONE : SEQ_IDLE);
        end
        SEQ_TWO: begin
          cif.strip = zero;
          seq_d = zero ? SEQ_THREE : SEQ_IDLE;
        end
        SEQ_THREE: begin
          // A broken code word is dropped rather than passed on as a pixel
          cif.strip = 1'b1;
          cif.code_hit = cif.lane[CODE_ONE_BIT];
          seq_d = SEQ_IDLE;
        end
        default: begin
          seq_d = SEQ_IDLE;
        end
      endcase
    end
  end

  // Sequence state
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      seq_q <= SEQ_IDLE;
    end else if (clear) begin
      seq_q <= SEQ_IDLE;
    end else begin
      seq_q <= seq_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // State parks between pixel edges, so the prior cycle may already be THREE
  property p_hit_needs_zeros;
    @(posedge clock) disable iff (sys_rst)
    cif.code_hit |-> seq_q == SEQ_THREE && $past(seq_q) inside {SEQ_TWO, SEQ_THREE};
  endproperty
  a_hit_needs_zeros: assert property (p_hit_needs_zeros)
    else $error("timing code reported without a full preamble");

endmodule

// File: core/cam_sensor_port.sv
// Parallel camera sensor input port with APB control registers.
// Assumes the sensor pins are asynchronous to clock and that the pixel
// clock is slow enough that each level lasts at least two clock periods.
`timescale 1ns/100ps

// Behaviour
// - three modes: embedded, gated, non-gated
// - embedded mode uses only pixel clock
// - decode, strip codes, regenerate frame/line syncs
// - 8-bit embedded: one component per clock
// - wide embedded: two components per clock
// - gated frame starts on frame sync edge
// - gated clocks valid only while line active
// - gated data captured on valid clock edge
// - line sync inactive stops capture until next
// - non-gated ignores line sync, all clocks valid
// - programmable frame, line, clock polarities
// - one-bit extension replicates the MSB
// - two-bit extension replicates two MSBs
// - 8-bit luma/chroma only in embedded mode
// - RGB16 generic or processed with restrictions
// - 16-bit luma/chroma passed as generic data
// - 20-bit luma/chroma only in wide embedded
module cam_sensor_port
  import cam_port_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cam_pixel_clock_in,
  input wire logic cam_frame_sync_in,
  input wire logic cam_line_sync_in,
  input wire logic [DATA_W-1:0] cam_pixel_data_bus,
  output logic [DATA_W-1:0] pix_data,
  output logic pix_valid,
  output logic pix_frame_start,
  output logic pix_line_start,
  output logic pix_line_end,
  output logic frame_sync_out,
  output logic line_sync_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic pclk_s1, pclk_s2, pclk_s3;
  logic fs_s1, fs_s2, fs_s3;
  logic ls_s1, ls_s2;
  logic [DATA_W-1:0] data_s1, data_s2;
  logic [CTRL_W-1:0] ctrl_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  trk_e trk_q;
  logic vblank_q, field_q, ls_act_q;
  logic [CNT_W-1:0] frame_cnt_q, pix_cnt_q, line_len_q;
  logic [DATA_W-1:0] pix_data_q;
  logic pix_valid_q, pix_frame_start_q, pix_line_start_q, pix_line_end_q;
  logic frame_sync_q, line_sync_q;
  mode_e mode;
  fmt_e fmt;
  logic cfg_ok, run, pclk_edge, fs_edge, ls_act, ls_rise, smp;
  logic emb, gated, nongated, sav, eav, frame_ev, line_start_ev, line_end_ev, cap;

  code_if cif ();

  timing_code_decoder u_decoder (
    .clock(clock),
    .sys_rst(sys_rst),
    .clear(!run),
    .cif(cif)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages before use; the third clock and frame stages only find edges
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      {pclk_s1, pclk_s2, pclk_s3} <= 3'h0;
      {fs_s1, fs_s2, fs_s3} <= 3'h0;
      {ls_s1, ls_s2} <= 2'h0;
      data_s1 <= 20'h00000;
      data_s2 <= 20'h00000;
    end else begin
      {pclk_s1, pclk_s2, pclk_s3} <= {cam_pixel_clock_in, pclk_s1, pclk_s2};
      {fs_s1, fs_s2, fs_s3} <= {cam_frame_sync_in, fs_s1, fs_s2};
      {ls_s1, ls_s2} <= {cam_line_sync_in, ls_s1};
      data_s1 <= cam_pixel_data_bus;
      data_s2 <= data_s1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  assign mode = mode_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign fmt = fmt_e'(ctrl_q[CTRL_FMT_LSB +: 2]);
  assign emb = mode == MODE_EMBEDDED;
  assign gated = mode == MODE_GATED;
  assign nongated = mode == MODE_NONGATED;
  // luma/chroma 8-bit and 20-bit need embedded sync
  // RGB and generic 16-bit need pin syncs
  assign cfg_ok = emb ? (fmt == FMT_YCC8 || fmt == FMT_YCC20) : ((gated || nongated) &&
                  (fmt == FMT_GENERIC16 || fmt == FMT_RGB565));
  assign run = ctrl_q[CTRL_EN_BIT] && cfg_ok;

  assign pclk_edge = ctrl_q[CTRL_PCLK_FALL_BIT] ? (pclk_s3 && !pclk_s2) : (!pclk_s3 && pclk_s2);
  assign fs_edge = ctrl_q[CTRL_FS_FALL_BIT] ? (fs_s3 && !fs_s2) : (!fs_s3 && fs_s2);
  assign ls_act = ls_s2 ^ ctrl_q[CTRL_LS_LOW_BIT];
  assign ls_rise = ls_act && !ls_act_q;
  assign smp = run && pclk_edge;

  // embedded timing comes from the data alone, via the decoder
  // wide protocol carries codes on the luma lane
  // 8-bit protocol, one component per edge
  assign cif.sample_valid = smp && emb;
  assign cif.lane = (fmt == FMT_YCC8) ? {data_s2[7:0], 2'b00} : data_s2[19:10];
  assign sav = cif.code_hit && !cif.code_h && !cif.code_v;
  assign eav = cif.code_hit && cif.code_h;

  // ----------------------------------------------------------------
  // Frame and line events
  // ----------------------------------------------------------------
  // an active SAV after vertical blanking starts the frame
  // frame sync edge starts each frame
  assign frame_ev = emb ? (sav && vblank_q) : (run && fs_edge);
  // gated line opens on a fresh line sync assertion
  assign line_start_ev = emb ? (sav && trk_q == TRK_FRAME) : (gated && trk_q == TRK_FRAME && ls_rise);
  // line sync dropping ends the line
  assign line_end_ev = emb ? (eav && trk_q == TRK_LINE) : (gated && trk_q == TRK_LINE && !ls_act);

  // non-gated takes every clock once the frame runs
  assign cap = smp && trk_q == TRK_LINE && !frame_ev &&
               ((emb && !cif.strip) || (gated && ls_act) || nongated);

  // Word assembly with colour extension per input format
  // one-bit widening repeats MSB
  function automatic logic [DATA_W-1:0] pixel_word(input fmt_e f, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] w;
    w = 20'h00000;
    case (f)
      FMT_YCC8: w = {10'h000, ext8to10(d[7:0])};
      FMT_YCC20: w = d;
      FMT_GENERIC16: w = {4'h0, d[15:0]};
      FMT_RGB565: w = {2'h0, ext5to6(d[15:11]), d[10:5], ext5to6(d[4:0])};
      default: w = d;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Frame and line tracking
  // ----------------------------------------------------------------
  // reset or disable drops to waiting for a frame start
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      trk_q <= TRK_WAIT;
    end else if (!run) begin
      trk_q <= TRK_WAIT;
    end else if (frame_ev) begin
      trk_q <= gated ? TRK_FRAME : TRK_LINE;
    end else begin
      case (trk_q)
        TRK_FRAME: if (line_start_ev) trk_q <= TRK_LINE;
        TRK_LINE: if (line_end_ev) trk_q <= TRK_FRAME;
        default: trk_q <= trk_q;
      endcase
    end
  end

  // Blanking, field and line sync history
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      vblank_q <= 1'b0;
      field_q <= 1'b0;
      ls_act_q <= 1'b0;
    end else begin
      ls_act_q <= ls_act;
      if (!run || frame_ev) begin
        vblank_q <= 1'b0;
      end else if (cif.code_hit && cif.code_v) begin
        vblank_q <= 1'b1;
      end
      if (cif.code_hit) begin
        field_q <= cif.code_f;
      end
    end
  end

  // Frame count and last completed line length
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      frame_cnt_q <= 16'h0000;
      pix_cnt_q <= 16'h0000;
      line_len_q <= 16'h0000;
    end else begin
      if (frame_ev) begin
        frame_cnt_q <= frame_cnt_q + 16'h0001;
      end
      if (line_end_ev) begin
        line_len_q <= pix_cnt_q;
        pix_cnt_q <= 16'h0000;
      end else if (frame_ev || line_start_ev) begin
        pix_cnt_q <= 16'h0000;
      end else if (cap) begin
        pix_cnt_q <= pix_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel stream outputs
  // ----------------------------------------------------------------
  // regenerated syncs and event pulses for downstream logic
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pix_data_q <= 20'h00000;
      pix_valid_q <= 1'b0;
      pix_frame_start_q <= 1'b0;
      pix_line_start_q <= 1'b0;
      pix_line_end_q <= 1'b0;
      frame_sync_q <= 1'b0;
      line_sync_q <= 1'b0;
    end else begin
      pix_valid_q <= cap;
      if (cap) begin
        pix_data_q <= pixel_word(fmt, data_s2);
      end
      pix_frame_start_q <= frame_ev;
      pix_line_start_q <= line_start_ev || (frame_ev && !gated);
      pix_line_end_q <= line_end_ev;
      frame_sync_q <= trk_q != TRK_WAIT;
      line_sync_q <= trk_q == TRK_LINE;
    end
  end

  assign pix_data = pix_data_q;
  assign pix_valid = pix_valid_q;
  assign pix_frame_start = pix_frame_start_q;
  assign pix_line_start = pix_line_start_q;
  assign pix_line_end = pix_line_end_q;
  assign frame_sync_out = frame_sync_q;
  assign line_sync_out = line_sync_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'b00} inside {CTRL_OFFS, STATUS_OFFS, FRAME_CNT_OFFS, LINE_LEN_OFFS};
  endfunction

  function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [31:0] r;
    r = 32'h00000000;
    case ({a[ADDR_W-1:2], 2'b00})
      CTRL_OFFS: r = {24'h000000, ctrl_q};
      STATUS_OFFS: r = {28'h0000000, field_q, !cfg_ok, trk_q == TRK_LINE, trk_q != TRK_WAIT};
      FRAME_CNT_OFFS: r = {16'h0000, frame_cnt_q};
      LINE_LEN_OFFS: r = {16'h0000, line_len_q};
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !reg_hit(paddr);
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= reg_read(paddr);
      end
    end
  end

  // Control writes land on the completing edge only
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (psel && penable && pready_q && pwrite &&
                 {paddr[ADDR_W-1:2], 2'b00} == CTRL_OFFS) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_wait_no_pixels;
    trk_q == TRK_WAIT |=> !pix_valid_q;
  endproperty
  a_wait_no_pixels: assert property (p_wait_no_pixels)
    else $error("pixel produced before a frame start");

  property p_line_off_blocks;
    gated && !ls_act |=> !pix_valid_q;
  endproperty
  a_line_off_blocks: assert property (p_line_off_blocks)
    else $error("pixel taken while line sync inactive");

  property p_gated_capture;
    gated && smp && trk_q == TRK_LINE && ls_act && !fs_edge |=>
      pix_valid_q && pix_data_q == pixel_word($past(fmt), $past(data_s2));
  endproperty
  a_gated_capture: assert property (p_gated_capture)
    else $error("valid gated clock edge did not capture data");

  property p_nongated_all;
    nongated && smp && trk_q == TRK_LINE && !fs_edge |=> pix_valid_q;
  endproperty
  a_nongated_all: assert property (p_nongated_all)
    else $error("non-gated clock edge dropped");

  property p_strip_codes;
    emb && cif.strip |=> !pix_valid_q;
  endproperty
  a_strip_codes: assert property (p_strip_codes)
    else $error("timing code word leaked into pixels");

  property p_frame_edge;
    !emb && run && fs_edge |=> pix_frame_start_q ##1 (frame_sync_q && !pix_frame_start_q);
  endproperty
  a_frame_edge: assert property (p_frame_edge)
    else $error("frame sync edge did not start a frame");

  property p_clock_polarity;
    run && ctrl_q[CTRL_PCLK_FALL_BIT] && !pclk_s3 && pclk_s2 |-> !smp;
  endproperty
  a_clock_polarity: assert property (p_clock_polarity)
    else $error("wrong pixel clock edge sampled");

  property p_bad_cfg;
    !cfg_ok |=> !pix_valid_q && !pix_frame_start_q;
  endproperty
  a_bad_cfg: assert property (p_bad_cfg)
    else $error("unsupported format produced output");

  property p_ext_two;
    pix_valid_q && $past(fmt) == FMT_YCC8 |->
      pix_data_q[1:0] == pix_data_q[9:8] && pix_data_q[19:10] == 10'h000;
  endproperty
  a_ext_two: assert property (p_ext_two)
    else $error("8-bit component not widened by two MSBs");

  property p_ext_one;
    pix_valid_q && $past(fmt) == FMT_RGB565 |->
      pix_data_q[0] == pix_data_q[5] && pix_data_q[12] == pix_data_q[17];
  endproperty
  a_ext_one: assert property (p_ext_one)
    else $error("5-bit component not widened by its MSB");

  property p_wide_pair;
    pix_valid_q && $past(fmt) == FMT_YCC20 |-> pix_data_q == $past(data_s2);
  endproperty
  a_wide_pair: assert property (p_wide_pair)
    else $error("wide word not taken whole");

  c_emb_frame: cover property (emb && frame_ev ##[1:1000] pix_valid_q);
  c_gated_line: cover property (gated && line_start_ev ##[1:1000] line_end_ev);
  c_nongated_pix: cover property (nongated && pix_valid_q);
  c_cfg_err: cover property (ctrl_q[CTRL_EN_BIT] && !cfg_ok);

endmodule

// File: verif/cam_sensor_model.sv
// Behavioural image sensor: makes pixel clock, frame/line syncs, data.
// Assumes the bench calls one task at a time, off the system clock edge.
`timescale 1ns/100ps
module cam_sensor_model
  import cam_port_pkg::*;
(
  output logic pclk,
  output logic fsync,
  output logic lsync,
  output logic [DATA_W-1:0] data
);
  // Pins idle low until the bench starts a frame
  initial begin
    pclk = 1'b0;
    fsync = 1'b0;
    lsync = 1'b0;
    data = '0;
  end

  // sensor owns the 320 ns clock, low between words
  task automatic px(input logic [DATA_W-1:0] d);
    // Data steady around both clock edges, so either sampling edge works
    data = d;
    #80 pclk = 1'b1;
    #160 pclk = 1'b0;
    #80 data = ~d; // Held value is gone once the word is taken
  endtask

  // frame sync edge is made by moving its level
  task automatic sync(input logic fs, input logic ls);
    fsync = fs;
    lsync = ls;
    #320;
  endtask

  // line sync active for the whole line
  task automatic line(input logic act, input int n, input logic [15:0] base);
    lsync = act;
    #320;
    for (int i = 0; i < n; i++) px({4'hF, base + 16'(i)});
    lsync = ~act;
    #320;
  endtask
endmodule

// File: verif/tb.sv
// Bench for the camera port: register access and the three timing modes.
// Assumes the sensor model pins change half a clock away from sampling.
`timescale 1ns/100ps
module tb;
  import cam_port_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, pclk, fsync, lsync, pix_valid, pix_frame_start;
  logic pix_line_start, pix_line_end, frame_sync_out, line_sync_out;
  logic [DATA_W-1:0] sdata, pix_data;
  logic [DATA_W-1:0] got_q[$], exp_q[$];
  logic [15:0] rgb[3] = '{16'hF81F, 16'h0400, 16'h8410};
  logic [7:0] emb[15] = '{8'hFF, 8'h00, 8'h00, 8'hA0, 8'hFF, 8'h00, 8'h00, 8'h80,
                          8'h11, 8'h5A, 8'hC3, 8'hFF, 8'h00, 8'h00, 8'h90};
  int miscompares = 0;
  int n_checks = 0;
  int nfs = 0;
  int nle = 0;
  int nls = 0;

  always #20 clock = ~clock;

  cam_sensor_model u_sen (.pclk(pclk), .fsync(fsync), .lsync(lsync), .data(sdata));

  cam_sensor_port u_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cam_pixel_clock_in(pclk), .cam_frame_sync_in(fsync),
    .cam_line_sync_in(lsync), .cam_pixel_data_bus(sdata), .pix_data(pix_data),
    .pix_valid(pix_valid), .pix_frame_start(pix_frame_start),
    .pix_line_start(pix_line_start), .pix_line_end(pix_line_end),
    .frame_sync_out(frame_sync_out), .line_sync_out(line_sync_out));

  // Collect one-cycle pulses in the cycle they stand
  always @(posedge clock) begin
    if (pix_valid === 1'b1) got_q.push_back(pix_data);
    if (pix_frame_start === 1'b1) nfs++;
    if (pix_line_end === 1'b1) nle++;
    if (pix_line_start === 1'b1) nls++;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmp(input logic [DATA_W-1:0] m, input int fs, input int ls, input int le,
                     input logic lo);
    repeat (12) @(posedge clock);
    chk("frames", nfs, fs);
    chk("line_starts", nls, ls);
    chk("line_ends", nle, le);
    chk("in_line", line_sync_out, lo);
    chk("pixels", got_q.size(), exp_q.size());
    foreach (exp_q[i]) chk("pix_data", got_q[i] & m, exp_q[i]);
    got_q = {};
    exp_q = {};
    nfs = 0;
    nle = 0;
    nls = 0;
  endtask

  // Embedded-sync word: 8-bit on [7:0], wide mode codes on the luma lane
  function automatic logic [DATA_W-1:0] ew(input logic f, input logic [7:0] b);
    return f ? {b, 2'b00, ~b, 2'b11} : {12'h0, b};
  endfunction

  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #300000;
    miscompares++;
    stop_test();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, CTRL_OFFS, 32'h0);
    chk("ctrl_reset", rd, 32'h0);
    apb(1'b1, CTRL_OFFS, 32'h1A5);
    apb(1'b0, CTRL_OFFS, 32'h0);
    chk("ctrl_rw", rd, 32'hA5);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    // Gated mode, straight then inverted frame and line polarity
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, CTRL_OFFS, 32'h0);
      @(negedge clock);
      u_sen.sync(p[0], p[0]);
      apb(1'b1, CTRL_OFFS, p ? 32'h9B : 32'h83);
      @(negedge clock);
      u_sen.sync(!p[0], p[0]);
      u_sen.line(!p[0], 3, 16'h1234);
      u_sen.px(20'hABCDE);
      u_sen.line(!p[0], 2, 16'hF0F0);
      for (int i = 0; i < 3; i++) exp_q.push_back({4'h0, 16'h1234 + 16'(i)});
      for (int i = 0; i < 2; i++) exp_q.push_back({4'h0, 16'hF0F0 + 16'(i)});
      chk("in_frame", frame_sync_out, 1'b1);
      cmp('1, 1, 2, 2, 1'b0);
    end
    // Non-gated RGB565 on the falling pixel clock, line sync left inactive
    apb(1'b1, CTRL_OFFS, 32'h0);
    @(negedge clock);
    u_sen.sync(1'b0, 1'b0);
    apb(1'b1, CTRL_OFFS, 32'hE5);
    @(negedge clock);
    u_sen.sync(1'b1, 1'b0);
    foreach (rgb[i]) u_sen.px({4'h0, rgb[i]});
    foreach (rgb[i]) exp_q.push_back({2'h0, rgb[i][15:11], rgb[i][15], rgb[i][10:5],
                                      rgb[i][4:0], rgb[i][4]});
    cmp('1, 1, 1, 0, 1'b1);
    // Embedded sync, 8-bit then wide
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, CTRL_OFFS, 32'h0);
      apb(1'b1, CTRL_OFFS, f ? 32'h41 : 32'h01);
      @(negedge clock);
      foreach (emb[i]) u_sen.px(ew(f[0], emb[i]));
      for (int i = 8; i < 11; i++)
        exp_q.push_back(f ? ew(1'b1, emb[i]) : {10'h0, emb[i], emb[i][7:6]});
      cmp(f ? 20'hFFFFF : 20'h003FF, 1, 1, 1, 1'b0);
    end
    // Register view of the frames seen so far
    apb(1'b0, FRAME_CNT_OFFS, 32'h0);
    chk("frame_cnt", rd, 32'h5);
    apb(1'b0, LINE_LEN_OFFS, 32'h0);
    chk("line_len", rd, 32'h3);
    apb(1'b0, STATUS_OFFS, 32'h0);
    chk("status", rd, 32'h1);
    // Reset in mid-frame drops tracking and settings
    chk("frame_before_reset", frame_sync_out, 1'b1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    chk("reset_frame", frame_sync_out, 1'b0);
    apb(1'b0, CTRL_OFFS, 32'h0);
    chk("ctrl_after_reset", rd, 32'h0);
    // Mode code 11 is no timing mode and is flagged
    apb(1'b1, CTRL_OFFS, 32'h7);
    apb(1'b0, STATUS_OFFS, 32'h0);
    chk("status_bad_mode", rd, 32'h4);
    stop_test();
  end
endmodule
